// >>> design/acr_ctrl_regs.sv
// control register decode, start sequencing and status register read path
`timescale 1ns/10ps
module acr_ctrl_regs
  import acr_pkg::*;
(
  input  wire logic        i_ref_clk,       // converter clock, 20 MHz
  input  wire logic        i_sys_rst,       // synchronous reset, active high
  input  wire logic        i_wr_n,          // byte write strobe pin, active low
  input  wire logic        i_rd_n,          // byte read strobe pin, active low
  input  wire logic        i_high_byte,     // byte select pin, 1 = high byte
  input  wire logic [7:0]  i_data,          // data lines in
  input  wire logic [11:0] i_conv_result,   // conversion result from the converter core
  input  wire logic [13:0] i_test_value,    // test register contents
  input  wire logic [13:0] i_cal_value,     // addressed calibration coefficient
  output logic      [7:0]  o_data,          // data lines out
  output logic             o_data_oe_n,     // data line enable, low while driving
  output logic      [1:0]  o_power_sel,     // power-down mode select
  output logic             o_input_range_sel, // 0 unipolar, 1 bipolar
  output logic      [1:0]  o_cal_reg_addr,  // calibration coefficient address
  output logic             o_test_wr,       // one-cycle pulse: 14-bit test write
  output logic             o_cal_wr,        // one-cycle pulse: 14-bit calibration write
  output logic      [13:0] o_wr_value,      // value for test or calibration write
  output logic             o_conv_busy,     // conversion in progress
  output logic             o_cal_busy,      // calibration in progress
  output acr_step_t        o_cal_step       // current calibration step
);

  typedef struct packed {
    logic [2:0]  wr_sync;
    logic [2:0]  rd_sync;
    logic [1:0]  hb_sync;
    logic [15:0] d_sync;
    logic [7:0]  low_byte;
    logic        low_seen;
    logic [13:0] control;
    acr_seq_t    seq;
    logic [1:0]  step_idx;
    logic [7:0]  count;
    logic [7:0]  data;
    logic        data_oe_n;
    logic        test_wr;
    logic        cal_wr;
    logic [13:0] wr_value;
    logic [1:0]  power;
    logic        range_sel;
    logic [1:0]  cal_addr;
    logic        conv_busy;
    logic        cal_busy;
    acr_step_t   step;
  } acr_state_t;

  acr_state_t r;
  acr_state_t next_r;
  acr_step_t  plan_step;
  acr_step_t  next_step;
  logic [1:0] next_idx;
  logic [7:0] next_len;
  logic       wr_fall;
  logic       rd_fall;
  logic       rd_rise;
  logic [15:0] word;
  logic [15:0] state_word;
  logic [15:0] read_word;
  logic [7:0]  step_len;

  acr_cal_plan u_plan (
    .i_code  (r.control[CTL_CLASS_POS:CTL_CAL_LO_POS]),
    .i_index (r.step_idx),
    .o_step  (plan_step)
  );

  // the step after the current one sets the length loaded at each hand-over
  assign next_idx = r.step_idx + 2'h1;

  acr_cal_plan u_plan_next (
    .i_code  (r.control[CTL_CLASS_POS:CTL_CAL_LO_POS]),
    .i_index (next_idx),
    .o_step  (next_step)
  );

  // stages [0] are read only by stage [1]; edges use later stages
  assign wr_fall = ~r.wr_sync[1] & r.wr_sync[2];
  assign rd_fall = ~r.rd_sync[1] & r.rd_sync[2];
  assign rd_rise = r.rd_sync[1] & ~r.rd_sync[2];
  assign word    = {r.d_sync[15:8], r.low_byte};

  always_comb begin
    unique case (plan_step)
      STEP_DAC_K:              step_len = STEP_DAC;
      STEP_IGAIN, STEP_SGAIN:  step_len = STEP_GAIN;
      default:                 step_len = STEP_OFFSET;
    endcase
  end

  always_comb begin
    unique case (next_step)
      STEP_DAC_K:              next_len = STEP_DAC;
      STEP_IGAIN, STEP_SGAIN:  next_len = STEP_GAIN;
      default:                 next_len = STEP_OFFSET;
    endcase
  end

  always_comb begin
    state_word = STATE_RESET;
    state_word[CTL_POWER_HI_POS:CTL_POWER_LO_POS] = r.control[CTL_POWER_HI_POS:CTL_POWER_LO_POS];
    state_word[CTL_READ_HI_POS:CTL_READ_LO_POS]   = STATE_ONES;
    state_word[CTL_RANGE_POS]   = r.control[CTL_RANGE_POS];
    state_word[CTL_CONV_GO_POS] = (r.seq != SEQ_IDLE);
    state_word[CTL_CLASS_POS:CTL_CAL_LO_POS] = r.control[CTL_CLASS_POS:CTL_CAL_LO_POS];
    state_word[CTL_CAL_GO_POS]  = r.control[CTL_CAL_GO_POS];
  end

  always_comb begin
    unique case (r.control[CTL_READ_HI_POS:CTL_READ_LO_POS])
      READ_DATA:  read_word = {4'h0, i_conv_result};
      READ_TEST:  read_word = {2'h0, i_test_value};
      READ_CAL:   read_word = {2'h0, i_cal_value};
      READ_STATE: read_word = state_word;
    endcase
  end

  always_comb begin
    next_r          = r;
    next_r.wr_sync  = {r.wr_sync[1:0], i_wr_n};
    next_r.rd_sync  = {r.rd_sync[1:0], i_rd_n};
    next_r.hb_sync  = {r.hb_sync[0], i_high_byte};
    next_r.d_sync   = {r.d_sync[7:0], i_data};
    next_r.test_wr  = 1'b0;
    next_r.cal_wr   = 1'b0;

    // the operation sequencer
    unique case (r.seq)
      SEQ_IDLE: ;
      SEQ_CONV: begin
        if (r.count == 8'h00) begin
          next_r.seq = SEQ_DONE;
        end else begin
          next_r.count = r.count - 8'h01;
        end
      end
      SEQ_CAL: begin
        if (plan_step == STEP_NONE) begin
          next_r.seq = SEQ_DONE;
        end else if (r.count == 8'h00) begin
          next_r.step_idx = r.step_idx + 2'h1;
          next_r.count    = next_len;
        end else begin
          next_r.count = r.count - 8'h01;
        end
      end
      SEQ_DONE: begin
        next_r.seq = SEQ_IDLE;
        next_r.control[CTL_CONV_GO_POS] = 1'b0;
        next_r.control[CTL_CAL_GO_POS]  = 1'b0;
      end
    endcase

    // byte pairing: low first, high completes the word
    if (wr_fall) begin
      if (!r.hb_sync[1]) begin
        next_r.low_byte = r.d_sync[15:8];
        next_r.low_seen = 1'b1;
      end else if (r.low_seen) begin
        next_r.low_seen = 1'b0;
        next_r.wr_value = word[13:0];
        unique case (word[WR_TARGET_HI_POS:WR_TARGET_LO_POS])
          TARGET_NONE: ;
          TARGET_TEST: next_r.test_wr = 1'b1;
          TARGET_CAL:  next_r.cal_wr  = 1'b1;
          TARGET_CONTROL: begin
            // a busy block keeps its running start bits and ignores new starts
            if (r.seq == SEQ_IDLE) begin
              next_r.control = word[13:0];
              next_r.control[CTL_ZERO_HI_POS:CTL_ZERO_LO_POS] = 4'h0;
              if (word[CTL_CAL_GO_POS]) begin
                next_r.seq      = SEQ_CAL;
                next_r.step_idx = 2'h0;
                next_r.count    = STEP_DAC;
                next_r.control[CTL_CONV_GO_POS] = 1'b0;
              end else if (word[CTL_CONV_GO_POS]) begin
                next_r.seq   = SEQ_CONV;
                next_r.count = CONV_CYCLES;
              end
            end else begin
              next_r.control[CTL_CAL_GO_POS:0] = r.control[CTL_CAL_GO_POS:0];
              next_r.control[CTL_POWER_HI_POS:CTL_RANGE_POS] = word[CTL_POWER_HI_POS:CTL_RANGE_POS];
            end
          end
        endcase
      end
    end

    // first step length follows the plan once the code is known
    if (r.seq == SEQ_CAL && r.step_idx == 2'h0 && r.count == STEP_DAC && plan_step != STEP_DAC_K) begin
      next_r.count = step_len;
    end

    // read drive: byte picked by the byte select pin
    if (rd_fall) begin
      next_r.data      = r.hb_sync[1] ? read_word[15:8] : read_word[7:0];
      next_r.data_oe_n = 1'b0;
    end else if (rd_rise) begin
      next_r.data_oe_n = 1'b1;
    end

    // output copies follow the settled next state, so they change with it, except the step copy, which lags one cycle
    next_r.power     = next_r.control[CTL_POWER_HI_POS:CTL_POWER_LO_POS];
    next_r.range_sel = next_r.control[CTL_RANGE_POS];
    next_r.cal_addr  = next_r.control[CTL_CAL_HI_POS:CTL_CAL_LO_POS];
    next_r.conv_busy = (next_r.seq == SEQ_CONV);
    next_r.cal_busy  = (next_r.seq == SEQ_CAL);
    next_r.step      = (r.seq == SEQ_CAL) ? plan_step : STEP_NONE;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r           <= '0;
      r.wr_sync   <= 3'h7;
      r.rd_sync   <= 3'h7;
      r.control   <= CONTROL_RESET;
      r.seq       <= SEQ_IDLE;
      r.data_oe_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign o_data            = r.data;
  assign o_data_oe_n       = r.data_oe_n;
  assign o_power_sel       = r.power;
  assign o_input_range_sel = r.range_sel;
  assign o_cal_reg_addr    = r.cal_addr;
  assign o_test_wr         = r.test_wr;
  assign o_cal_wr          = r.cal_wr;
  assign o_wr_value        = r.wr_value;
  assign o_conv_busy       = r.conv_busy;
  assign o_cal_busy        = r.cal_busy;
  assign o_cal_step        = r.step;

endmodule

// >>> design/acr_pkg.sv
// package: field layout, codes, timing constants for the converter control and status block
package acr_pkg;

  // write word layout
  localparam int WR_TARGET_HI_POS = 15;
  localparam int WR_TARGET_LO_POS = 14;
  localparam logic [1:0] TARGET_NONE    = 2'h0;
  localparam logic [1:0] TARGET_TEST    = 2'h1;
  localparam logic [1:0] TARGET_CAL     = 2'h2;
  localparam logic [1:0] TARGET_CONTROL = 2'h3;

  // control field positions
  localparam int CTL_ZERO_HI_POS  = 13;
  localparam int CTL_ZERO_LO_POS  = 10;
  localparam int CTL_POWER_HI_POS = 9;
  localparam int CTL_POWER_LO_POS = 8;
  localparam int CTL_READ_HI_POS  = 7;
  localparam int CTL_READ_LO_POS  = 6;
  localparam int CTL_RANGE_POS    = 5;
  localparam int CTL_CONV_GO_POS  = 4;
  localparam int CTL_CLASS_POS    = 3;
  localparam int CTL_CAL_HI_POS   = 2;
  localparam int CTL_CAL_LO_POS   = 1;
  localparam int CTL_CAL_GO_POS   = 0;

  localparam logic [13:0] CONTROL_RESET = 14'h0000;
  localparam logic [15:0] STATE_RESET   = 16'h0000;
  localparam logic [1:0]  STATE_ONES    = 2'h3;

  // read select codes
  localparam logic [1:0] READ_DATA   = 2'h0;
  localparam logic [1:0] READ_TEST   = 2'h1;
  localparam logic [1:0] READ_CAL    = 2'h2;
  localparam logic [1:0] READ_STATE  = 2'h3;

  // durations of each step less one, in clock cycles
  localparam logic [7:0] CONV_CYCLES   = 8'h10;
  localparam logic [7:0] STEP_DAC      = 8'h40;
  localparam logic [7:0] STEP_GAIN     = 8'h20;
  localparam logic [7:0] STEP_OFFSET   = 8'h20;

  // calibration step kinds
  typedef enum logic [2:0] {
    STEP_NONE     = 3'h0,
    STEP_DAC_K    = 3'h1,
    STEP_IGAIN    = 3'h2,
    STEP_IOFFSET  = 3'h3,
    STEP_SGAIN    = 3'h4,
    STEP_SOFFSET  = 3'h5
  } acr_step_t;

  // top-level sequencer states, gray along idle->conv->cal->done
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_CAL  = 2'b11,
    SEQ_DONE = 2'b10
  } acr_seq_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] data;
    logic       high_byte;
  } acr_byte_wr_t;

  typedef struct packed {
    logic [1:0] power_sel;
    logic       input_range_sel;
    logic       busy;
    logic       conv_active;
    logic       cal_active;
    acr_step_t  step;
  } acr_status_t;

endpackage

// >>> design/acr_cal_plan.sv
// calibration step planner: maps a calibration code and step index to a step kind
`timescale 1ns/10ps
module acr_cal_plan
  import acr_pkg::*;
(
  input  wire logic [2:0] i_code,   // class, select hi, select lo
  input  wire logic [1:0] i_index,  // step number in the sequence
  output acr_step_t       o_step    // step kind, none past the end
);

  always_comb begin
    o_step = STEP_NONE;
    unique case (i_code)
      3'h0: begin
        unique case (i_index)
          2'h0:    o_step = STEP_DAC_K;
          2'h1:    o_step = STEP_IGAIN;
          2'h2:    o_step = STEP_IOFFSET;
          default: o_step = STEP_NONE;
        endcase
      end
      3'h1: o_step = (i_index == 2'h0) ? STEP_IGAIN : ((i_index == 2'h1) ? STEP_IOFFSET : STEP_NONE);
      3'h2: o_step = (i_index == 2'h0) ? STEP_IOFFSET : STEP_NONE;
      3'h3: o_step = (i_index == 2'h0) ? STEP_IGAIN : STEP_NONE;
      3'h4: begin
        unique case (i_index)
          2'h0:    o_step = STEP_DAC_K;
          2'h1:    o_step = STEP_SGAIN;
          2'h2:    o_step = STEP_SOFFSET;
          default: o_step = STEP_NONE;
        endcase
      end
      3'h5: o_step = (i_index == 2'h0) ? STEP_SGAIN : ((i_index == 2'h1) ? STEP_SOFFSET : STEP_NONE);
      3'h6: o_step = (i_index == 2'h0) ? STEP_SOFFSET : STEP_NONE;
      3'h7: o_step = (i_index == 2'h0) ? STEP_SGAIN : STEP_NONE;
    endcase
  end

endmodule

// >>> tb/acr_ctrl_regs_assertions.sv
// port assertions for the converter control and status block
`timescale 1ns/10ps
module acr_ctrl_regs_checker
  import acr_pkg::*;
(
  input wire logic       i_ref_clk,         // clock
  input wire logic       i_sys_rst,         // reset, active high
  input wire logic       i_wr_n,            // write strobe
  input wire logic       i_rd_n,            // read strobe
  input wire logic       o_data_oe_n,       // data drive enable
  input wire logic [1:0] o_power_sel,       // power mode
  input wire logic       o_input_range_sel, // range select
  input wire logic       o_test_wr,         // test write pulse
  input wire logic       o_cal_wr,          // cal write pulse
  input wire logic       o_conv_busy,       // converting
  input wire logic       o_cal_busy,        // calibrating
  input wire acr_step_t  o_cal_step         // current step
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  reset_clears_a: assert property ($fell(i_sys_rst) |-> !o_conv_busy && !o_cal_busy && o_data_oe_n
    && o_power_sel == 2'h0) else $error("outputs not cleared by reset");
  conv_length_a: assert property ($rose(o_conv_busy) |-> ##16 o_conv_busy ##1 !o_conv_busy)
    else $error("conversion length wrong");
  one_job_a: assert property (!(o_conv_busy && o_cal_busy)) else $error("two jobs at once");
  dac_next_a: assert property ($changed(o_cal_step) && $past(o_cal_step) == STEP_DAC_K
    |-> o_cal_step inside {STEP_IGAIN, STEP_SGAIN}) else $error("wrong step after dac");
  gain_next_a: assert property ($changed(o_cal_step) && $past(o_cal_step) == STEP_IGAIN
    |-> o_cal_step inside {STEP_IOFFSET, STEP_NONE}) else $error("wrong step after gain");
  step_in_cal_a: assert property (o_cal_step != STEP_NONE |-> o_cal_busy) else $error("step while idle");
  cal_bounded_a: assert property ($rose(o_cal_busy) |-> ##[1:200] !o_cal_busy)
    else $error("calibration never ends");
  fields_hold_a: assert property (i_wr_n [*8] |=> $stable(o_power_sel) && $stable(o_input_range_sel))
    else $error("fields moved without write");
  read_release_a: assert property (i_rd_n [*6] |=> o_data_oe_n) else $error("driving without read");
  pulse_once_a: assert property (o_test_wr || o_cal_wr |=> !o_test_wr && !o_cal_wr)
    else $error("write pulse too long");
endmodule

bind acr_ctrl_regs acr_ctrl_regs_checker i_acr_ctrl_regs_checker (.i_ref_clk, .i_sys_rst, .i_wr_n, .i_rd_n,
  .o_data_oe_n, .o_power_sel, .o_input_range_sel, .o_test_wr, .o_cal_wr, .o_conv_busy, .o_cal_busy, .o_cal_step);

// >>> tb/acr_host_model.sv
// host processor model on the byte-wide write and read pins
`timescale 1ns/10ps
module acr_host_model (
  input  wire logic       i_clk,   // bus clock
  input  wire logic [7:0] i_rdata, // data from the device
  input  wire logic       i_oe_n,  // device drives, low active
  output logic            o_wr_n,  // write strobe
  output logic            o_rd_n,  // read strobe
  output logic            o_hb,    // byte select
  output logic      [7:0] o_wdata  // data to the device
);
  int gap = 4;
  initial begin
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_hb = 1'b0;
    o_wdata = 8'h00;
  end
  // strobes held at least 3 clocks each way for the device synchroniser
  task automatic put_byte(input logic hb, input logic [7:0] b);
    @(posedge i_clk);
    o_hb <= hb;
    o_wdata <= b;
    o_wr_n <= 1'b0;
    repeat (gap) @(posedge i_clk);
    o_wr_n <= 1'b1;
    repeat (gap) @(posedge i_clk);
    o_wdata <= ~b; // released lines must not keep the byte
  endtask
  task automatic write_word(input logic [1:0] t, input logic [13:0] d);
    logic [15:0] w;
    w = {t, d};
    if (t == 2'h3) w[13:10] = 4'h0;
    put_byte(1'b0, w[7:0]);
    put_byte(1'b1, w[15:8]);
  endtask
  task automatic read_byte(input logic hb, output logic [7:0] b);
    @(posedge i_clk);
    o_hb <= hb;
    o_rd_n <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(posedge i_clk);
      #1;
      if (!i_oe_n) break;
    end
    b = i_rdata;
    @(posedge i_clk);
    o_rd_n <= 1'b1;
    repeat (gap) @(posedge i_clk);
  endtask
endmodule

// >>> tb/acr_ctrl_regs_tb_top.sv
// top testbench for the converter control and status block
`timescale 1ns/10ps
module acr_ctrl_regs_tb_top;
  import acr_pkg::*;
  logic        ref_clk, sys_rst, wr_n, rd_n, hb, oe_n, test_wr, cal_wr, range_sel, conv_busy, cal_busy;
  logic [7:0]  wdata, rdata, lo, hi;
  logic [11:0] conv_result;
  logic [13:0] test_value, cal_value, wr_value, last_wr, v;
  logic [1:0]  power_sel, cal_addr;
  logic [8:0]  seen_steps;
  acr_step_t   step;
  int          mismatches = 0, comparisons = 0, n_test = 0, n_cal = 0, nt, nc;

  acr_ctrl_regs i_acr_ctrl_regs (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_wr_n(wr_n), .i_rd_n(rd_n),
    .i_high_byte(hb), .i_data(wdata), .i_conv_result(conv_result), .i_test_value(test_value),
    .i_cal_value(cal_value), .o_data(rdata), .o_data_oe_n(oe_n), .o_power_sel(power_sel),
    .o_input_range_sel(range_sel), .o_cal_reg_addr(cal_addr), .o_test_wr(test_wr), .o_cal_wr(cal_wr),
    .o_wr_value(wr_value), .o_conv_busy(conv_busy), .o_cal_busy(cal_busy), .o_cal_step(step));
  acr_host_model i_acr_host_model (.i_clk(ref_clk), .i_rdata(rdata), .i_oe_n(oe_n), .o_wr_n(wr_n),
    .o_rd_n(rd_n), .o_hb(hb), .o_wdata(wdata));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (test_wr === 1'b1) n_test++;
    if (cal_wr === 1'b1) n_cal++;
    if (test_wr || cal_wr) last_wr = wr_value;
    if (step != STEP_NONE && step != seen_steps[2:0]) seen_steps = {seen_steps[5:0], step};
  end

  task automatic check(input string name, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] t, input logic [13:0] d);
    i_acr_host_model.write_word(t, d);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd16(output logic [15:0] r);
    i_acr_host_model.read_byte(1'b0, lo);
    i_acr_host_model.read_byte(1'b1, hi);
    r = {hi, lo};
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 300 && (cal_busy !== 1'b0 || conv_busy !== 1'b0); i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  function automatic logic [15:0] stat(input logic [13:0] c, input logic busy);
    return {6'h00, c[9:8], 2'h3, c[5], busy, c[3:0]};
  endfunction
  function automatic logic [8:0] plan(input logic [2:0] c);
    logic [2:0] g, o;
    g = c[2] ? STEP_SGAIN : STEP_IGAIN;
    o = c[2] ? STEP_SOFFSET : STEP_IOFFSET;
    case (c[1:0])
      2'h0: return {STEP_DAC_K, g, o};
      2'h1: return {3'h0, g, o};
      2'h2: return {6'h00, o};
      default: return {6'h00, g};
    endcase
  endfunction
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [15:0] r;
    void'($urandom(26894));
    sys_rst = 1'b1;
    conv_result = 12'($urandom());
    test_value = 14'($urandom());
    cal_value = 14'($urandom());
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd16(r);
    check("default read", r, {4'h0, conv_result});
    for (int k = 0; k < 4; k++) begin
      i_acr_host_model.gap = 3 + int'($urandom() % 3);
      v = (14'($urandom()) & 14'h032e) | 14'h00c0;
      wr(2'h3, v);
      check("power", 16'(power_sel), 16'(v[9:8]));
      check("range", 16'(range_sel), 16'(v[5]));
      check("cal address", 16'(cal_addr), 16'(v[2:1]));
      rd16(r);
      check("status", r, stat(v, 1'b0));
    end
    seen_steps = 9'h000;
    wr(2'h3, 14'h00c1);
    rd16(r);
    check("status cal", r, stat(14'h00c1, 1'b1));
    wr(2'h3, 14'h00d0);
    check("refused start", 16'(conv_busy), 16'h0000);
    wait_idle();
    check("full cal", 16'(seen_steps), 16'(plan(3'h0)));
    rd16(r);
    check("start cleared", r, stat(14'h00c0, 1'b0));
    wr(2'h3, 14'h00d0);
    check("conv busy", 16'(conv_busy), 16'h0001);
    wait_idle();
    rd16(r);
    check("conv cleared", r, stat(14'h00c0, 1'b0));
    for (int c = 1; c < 8; c++) begin
      seen_steps = 9'h000;
      wr(2'h3, {8'h03, 2'h0, 3'(c), 1'b1});
      wait_idle();
      check("cal plan", 16'(seen_steps), 16'(plan(3'(c))));
    end
    for (int t = 0; t < 3; t++) begin
      v = 14'($urandom());
      nt = n_test;
      nc = n_cal;
      wr(2'(t), v);
      check("test pulses", 16'(n_test - nt), 16'(t == 1));
      check("cal pulses", 16'(n_cal - nc), 16'(t == 2));
      if (t > 0) check("write value", 16'(last_wr), 16'(v));
    end
    for (int s = 1; s < 3; s++) begin
      wr(2'h3, 14'(s) << 6);
      rd16(r);
      check("select read", r, {2'h0, (s == 1) ? test_value : cal_value});
    end
    report_and_stop();
  end
endmodule
